// ### logic/uart_buf.sv
/*
  Transmit buffer, shift logic, flags, interrupt requests and two-entry
  receive FIFO of an asynchronous/synchronous serial transceiver.
  Assumes an external bit-rate enable pulse and synchronous pin inputs.
*/
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////
// Function
// R1 - Empty flag mirrors transmit buffer occupancy
// R2 - Data register write clears empty flag
// R3 - Empty interrupt requested while flag set
// R4 - Host writes data or masks empty interrupt
// R5 - Host writes zero to empty flag
// R6 - Complete flag when shifter and buffer idle
// R7 - Complete cleared by service or write one
// R8 - Complete interrupt follows complete flag
// R9 - Parity inserted before first stop bit
// R10 - Transmitter disable deferred until idle
// R11 - Receiver enable takes over receive pin
// R12 - Synchronous mode uses transfer clock pin
// R13 - Frame begins on valid start bit
// R14 - Second stop bit never examined
// R15 - First stop bit moves frame to FIFO
// R16 - Unused upper data bits read zero
// R17 - Receive complete flag marks unread data
// R18 - FIFO holds ninth bit and errors
// R19 - Host reads ninth bit before data
// R20 - Ninth bit marks address frames
// R21 - Host writes ninth bit before data
// R22 - Shifter loads when idle or after stop
// R23 - Parity is xor, inverted for odd
// R24 - Receiver disable flushes FIFO immediately
// R25 - FIFO holds two complete entries
module uart_buf
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  // Register port
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Interrupt handshake
  input  wire logic       global_irq_enable_i,
  input  wire logic       tx_complete_irq_ack_i,
  output logic            tx_empty_irq_o,
  output logic            tx_complete_irq_o,
  output logic            rx_complete_o,
  // Bit timing
  input  wire logic       baud_tick_i,
  input  wire logic       sync_transfer_clock_pin_i,
  // Serial pins
  input  wire logic       rx_pin_i,
  output logic            tx_pin_o,
  output logic            tx_pin_oe_o,
  output logic            rx_pin_owned_o
);
  import uart_buf_pkg::*;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_PAR = 3'h2,
    TX_STOP = 3'h6
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_DATA = 3'h1, RX_PAR = 3'h3, RX_STOP = 3'h2
  } rx_state_e;

  //////////////////////////////////////////////////////////////////////////
  logic [7:0] control;
  logic [7:0] format;
  logic       tx_enable_active;
  logic [8:0] tx_buffer;
  logic       tx_buffer_full;
  logic       tx_complete_flag;
  tx_state_e  tx_state;
  logic [8:0] tx_shift;
  logic [3:0] tx_count;
  logic       tx_stop_two;
  logic       tx_parity;
  rx_state_e  rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_count;
  logic       rx_parity;
  logic       overrun_pending;
  logic [11:0] fifo_mem [FIFO_DEPTH];
  logic       fifo_rd_ptr;
  logic       fifo_wr_ptr;
  logic [1:0] fifo_level;
  logic       sync_clk_q;

  logic       tx_buffer_empty_flag;
  logic [2:0] char_size_code;
  logic [3:0] data_bits;
  logic       parity_enable_bit;
  logic       parity_odd_select;
  logic       bit_tick;
  logic       data_write;
  logic       data_read;
  logic       tx_load;
  logic       tx_done;
  logic       rx_push;
  logic       fifo_pop;
  logic [11:0] head;
  logic [8:0] data_mask;

  assign char_size_code    = format[FM_SZ_LO +: 3];
  assign data_bits         = (char_size_code == SIZE_NINE) ? 4'h9
                           : {1'b0, char_size_code} + 4'h5;
  assign parity_enable_bit = format[FM_PEN];
  assign parity_odd_select = format[FM_PODD];
  assign data_write        = wr_i && addr_i == OFS_DATA;
  assign data_read         = rd_i && addr_i == OFS_DATA;
  assign tx_buffer_empty_flag = !tx_buffer_full;                       // R1
  // Rising edge of the transfer clock replaces the baud tick
  assign bit_tick = format[FM_SYNC] ? (sync_transfer_clock_pin_i && !sync_clk_q)
                                    : baud_tick_i;                    // R12
  assign data_mask = (char_size_code == SIZE_NINE) ? 9'h1ff
                   : 9'h0ff >> (4'h8 - data_bits);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      sync_clk_q <= 1'b0;
    else
      sync_clk_q <= sync_transfer_clock_pin_i;

  // Control and format registers
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      control <= CONTROL_RESET;
      format  <= FORMAT_RESET;
    end
    else if (wr_i && addr_i == OFS_CONTROL)
      control <= {wdata_i[7:2], control[CT_RX_NINTH], wdata_i[CT_TX_NINTH]};
    else if (wr_i && addr_i == OFS_FORMAT)
      format <= wdata_i;

  // Transmitter keeps the pin until both buffer and shifter drain
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      tx_enable_active <= 1'b0;
    else if (control[CT_TX_ON])
      tx_enable_active <= 1'b1;
    else if (!tx_buffer_full && tx_state == TX_IDLE)
      tx_enable_active <= 1'b0;                                       // R10

  //////////////////////////////////////////////////////////////////////////
  assign tx_load = tx_buffer_full && tx_enable_active &&
                   (tx_state == TX_IDLE || tx_done);                  // R22
  assign tx_done = tx_state == TX_STOP && bit_tick && !tx_stop_two &&
                   tx_count == 4'h0;

  // Write beside a load keeps the new character buffered
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      tx_buffer      <= 9'h000;
      tx_buffer_full <= 1'b0;
    end
    else if (data_write)
    begin
      tx_buffer      <= {control[CT_TX_NINTH], wdata_i} & data_mask;
      tx_buffer_full <= 1'b1;                                         // R2
    end
    else if (tx_load)
      tx_buffer_full <= 1'b0;                                         // R1

  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      tx_state    <= TX_IDLE;
      tx_shift    <= 9'h000;
      tx_count    <= 4'h0;
      tx_stop_two <= 1'b0;
      tx_parity   <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_state    <= TX_START;
      tx_shift    <= tx_buffer;
      tx_count    <= data_bits;
      tx_stop_two <= format[FM_STOP2];
      tx_parity   <= ^tx_buffer ^ parity_odd_select;                   // R23
    end
    else if (bit_tick)
      case (tx_state)
        TX_START: tx_state <= TX_DATA;
        TX_DATA:
        begin
          tx_shift <= tx_shift >> 1;
          tx_count <= tx_count - 4'h1;
          if (tx_count == 4'h1)
            tx_state <= parity_enable_bit ? TX_PAR : TX_STOP;         // R9
        end
        TX_PAR: tx_state <= TX_STOP;
        TX_STOP:
          if (tx_stop_two)
            tx_stop_two <= 1'b0;
          else
            tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase

  // Set wins over software or acknowledge clear
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      tx_complete_flag <= 1'b0;
    else if (tx_done && !tx_buffer_full)
      tx_complete_flag <= 1'b1;                                       // R6
    else if (tx_complete_irq_ack_i ||
             (wr_i && addr_i == OFS_STATUS && wdata_i[ST_TX_DONE]))
      tx_complete_flag <= 1'b0;                                       // R7

  always_comb
  begin
    tx_pin_oe_o = tx_enable_active;
    case (tx_state)
      TX_START: tx_pin_o = 1'b0;
      TX_DATA:  tx_pin_o = tx_shift[0];
      TX_PAR:   tx_pin_o = tx_parity;
      default:  tx_pin_o = 1'b1;
    endcase
  end

  assign tx_empty_irq_o = global_irq_enable_i && control[CT_EMPTY_IE] &&
                          tx_buffer_empty_flag;                       // R3
  assign tx_complete_irq_o = global_irq_enable_i && control[CT_DONE_IE] &&
                             tx_complete_flag;                        // R8

  //////////////////////////////////////////////////////////////////////////
  assign rx_pin_owned_o = control[CT_RX_ON];                          // R11
  assign rx_push = rx_state == RX_STOP && bit_tick && fifo_level != 2'h2; // R15
  assign fifo_pop = data_read && fifo_level != 2'h0;

  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      rx_state  <= RX_IDLE;
      rx_shift  <= 9'h000;
      rx_count  <= 4'h0;
      rx_parity <= 1'b0;
    end
    else if (!control[CT_RX_ON])
      rx_state <= RX_IDLE;                                            // R24
    else if (bit_tick)
      case (rx_state)
        RX_IDLE:
          if (!rx_pin_i)
          begin
            rx_state <= RX_DATA;                                      // R13
            rx_count <= data_bits;
            rx_shift <= 9'h000;
          end
        RX_DATA:
        begin
          rx_shift <= {rx_pin_i, rx_shift[8:1]};
          rx_count <= rx_count - 4'h1;
          if (rx_count == 4'h1)
            rx_state <= parity_enable_bit ? RX_PAR : RX_STOP;
        end
        RX_PAR:
        begin
          rx_parity <= rx_pin_i;
          rx_state  <= RX_STOP;
        end
        RX_STOP:
          if (fifo_level != 2'h2)
            rx_state <= RX_IDLE;                                      // R14
        default: rx_state <= RX_IDLE;
      endcase

  // Frame waits in the shifter when both entries are taken
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      overrun_pending <= 1'b0;
    else if (!control[CT_RX_ON] || rx_push)
      overrun_pending <= 1'b0;
    else if (rx_state == RX_STOP && bit_tick && !rx_pin_i)
      overrun_pending <= 1'b1;

  logic [8:0] rx_aligned;
  assign rx_aligned = (rx_shift >> (4'h9 - data_bits)) & data_mask;   // R16

  for (genvar g = 0; g < FIFO_DEPTH; g++)
  begin : g_fifo
    always_ff @(posedge clock_i or negedge nrst_i)
      if (!nrst_i)
        fifo_mem[g] <= 12'h000;
      else if (rx_push && fifo_wr_ptr == 1'(g))
        fifo_mem[g] <= {rx_aligned, !rx_pin_i, overrun_pending,
                        parity_enable_bit && (rx_parity !=
                        (^rx_aligned ^ parity_odd_select))};           // R18
  end

  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      fifo_rd_ptr <= 1'b0;
      fifo_wr_ptr <= 1'b0;
      fifo_level  <= 2'h0;
    end
    else if (!control[CT_RX_ON])
    begin
      fifo_rd_ptr <= 1'b0;
      fifo_wr_ptr <= 1'b0;
      fifo_level  <= 2'h0;                                            // R24
    end
    else
    begin
      if (rx_push)
        fifo_wr_ptr <= !fifo_wr_ptr;
      if (fifo_pop)
        fifo_rd_ptr <= !fifo_rd_ptr;                                  // R18
      fifo_level <= fifo_level + {1'b0, rx_push} - {1'b0, fifo_pop};  // R25
    end

  assign head = fifo_mem[fifo_rd_ptr];
  assign rx_complete_o = fifo_level != 2'h0;                          // R17

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      if (addr_i == OFS_DATA)
        rdata_o <= head[10:3];
      else if (addr_i == OFS_STATUS)
        rdata_o <= {rx_complete_o, tx_complete_flag, tx_buffer_empty_flag,
                    head[2:0] & {3{rx_complete_o}}, 2'h0};
      else if (addr_i == OFS_CONTROL)
        rdata_o <= {control[7:2], head[11], control[CT_TX_NINTH]};     // R20
      else
        rdata_o <= format;
    end
    else
      rdata_o <= 8'h00;

  //////////////////////////////////////////////////////////////////////////
  chk_empty_after_write: assert property (@(posedge clock_i) disable iff (!nrst_i) // R2
    data_write |=> !tx_buffer_empty_flag) else $error("empty flag not cleared");
  chk_empty_irq_level: assert property (@(posedge clock_i) disable iff (!nrst_i) // R3
    (tx_empty_irq_o && !data_write) |=> (tx_empty_irq_o || !global_irq_enable_i ||
    !control[CT_EMPTY_IE])) else $error("empty irq dropped");
  chk_done_flag_set: assert property (@(posedge clock_i) disable iff (!nrst_i) // R6
    (tx_done && !tx_buffer_full) |=> tx_complete_flag) else $error("complete flag not set");
  chk_done_write_clear: assert property (@(posedge clock_i) disable iff (!nrst_i) // R7
    (wr_i && addr_i == OFS_STATUS && wdata_i[ST_TX_DONE] && !tx_done)
    |=> !tx_complete_flag) else $error("complete flag not cleared");
  chk_tx_disable_hold: assert property (@(posedge clock_i) disable iff (!nrst_i) // R10
    (tx_state != TX_IDLE) |=> tx_pin_oe_o) else $error("pin released early");
  sequence s_rx_off;
    !control[CT_RX_ON];
  endsequence
  chk_rx_flush: assert property (@(posedge clock_i) disable iff (!nrst_i) // R24
    s_rx_off |=> (fifo_level == 2'h0 && rx_state == RX_IDLE))
    else $error("receiver not flushed");
  chk_fifo_bound: assert property (@(posedge clock_i) disable iff (!nrst_i) // R25
    fifo_level <= 2'h2) else $error("fifo over two");
  chk_rx_flag_push: assert property (@(posedge clock_i) disable iff (!nrst_i) // R17
    (rx_push && control[CT_RX_ON]) |=> rx_complete_o) else $error("receive flag not set");
  chk_read_zero_next: assert property (@(posedge clock_i) disable iff (!nrst_i) // Read data returns to zero after any cycle without a read
    !rd_i |=> rdata_o == 8'h00) else $error("read data not zero");

endmodule // uart_buf

// ### shared/uart_buf_pkg.sv
/*
  Constants for the serial transceiver buffer and flag block: register
  offsets, bit positions, reset values and frame-size codes.
  Assumes a byte-wide register port and a one-cycle bit-rate enable.
*/
package uart_buf_pkg;
  localparam logic [1:0] OFS_DATA    = 2'h0;
  localparam logic [1:0] OFS_STATUS  = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_FORMAT  = 2'h3;
  // Status bits
  localparam int ST_RX_DONE   = 7;
  localparam int ST_TX_DONE   = 6;
  localparam int ST_TX_EMPTY  = 5;
  localparam int ST_FRAME_ERR = 4;
  localparam int ST_OVERRUN   = 3;
  localparam int ST_PAR_ERR   = 2;
  // Control bits
  localparam int CT_EMPTY_IE = 5;
  localparam int CT_DONE_IE  = 6;
  localparam int CT_RX_ON    = 4;
  localparam int CT_TX_ON    = 3;
  localparam int CT_RX_NINTH = 1;
  localparam int CT_TX_NINTH = 0;
  // Format bits
  localparam int FM_STOP2 = 7;
  localparam int FM_PEN   = 5;
  localparam int FM_PODD  = 4;
  localparam int FM_SYNC  = 3;
  localparam int FM_SZ_LO = 0;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET  = 8'h06;
  localparam int FIFO_DEPTH = 2;
endpackage

// ### test/uart_partner.sv
/*
  Remote serial transceiver model: sends frames on the receive line
  and collects the frames seen on the transmit line.
  Assumes one bit per tick and idle-high lines.
*/
`timescale 1ns/1ps
module uart_partner (
  // Clock and timing
  input  wire logic clock_i,
  input  wire logic tick_i,
  // Serial lines
  input  wire logic tx_i,
  output logic      rx_o
);
  int          nb  = 8;
  bit          pen = 0;
  logic [10:0] q[$];
  logic [10:0] f;
  initial rx_o = 1'b1;
  // Sample just after each tick edge, when the new bit is settled
  initial forever
  begin
    @(posedge clock_i);
    #1;
    if (tx_i === 1'b0)
    begin
      f = '0;
      for (int i = 0; i < nb + pen + 1; i++)
      begin
        @(posedge clock_i iff tick_i);
        #1;
        f[i] = tx_i;
      end
      q.push_back(f);
    end
  end
  // One stop bit only, idle high afterwards
  task automatic send(input logic [8:0] d, input logic par);
    rx_o <= 1'b0;
    @(posedge clock_i iff tick_i);
    for (int i = 0; i < nb + pen + 1; i++)
    begin
      rx_o <= (i < nb) ? d[i] : (i == nb && pen) ? par : 1'b1;
      @(posedge clock_i iff tick_i);
    end
  endtask
endmodule // uart_partner

// ### test/testbench.sv
/*
  Self-checking bench for the serial buffer and flag block.
  Assumes the partner model on the serial lines, a 1-in-4 bit tick and a
  1-in-8 transfer clock pulse for the synchronous pass.
*/
`timescale 1ns/1ps
module testbench;
  import uart_buf_pkg::*;
  logic        clock_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
  logic        gie = 1, ack = 0, tick = 0, sync_transfer_clock_pin = 0;
  logic [1:0]  addr_i = '0;
  logic [2:0]  tcnt = '0;
  logic [7:0]  wdata_i = '0, rdata_o, r;
  logic        irq_e, irq_c, rx_ready, tx, oe, own, rx;
  logic [10:0] f;
  logic [8:0]  dd[2];
  logic [2:0]  code;
  bit          pe, po, ts, sm;
  int          nb, fails = 0, n_tests = 0, seed = 32'h2b2c;

  initial forever #2 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt[1:0] == 2'h3);
    // Transfer clock at half the bit rate, so a wrong tick source shows
    sync_transfer_clock_pin  <= (tcnt == 3'h5);
  end

  uart_buf uart_buf_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .global_irq_enable_i(gie),
    .tx_complete_irq_ack_i(ack), .tx_empty_irq_o(irq_e), .tx_complete_irq_o(irq_c),
    .rx_complete_o(rx_ready), .baud_tick_i(tick), .sync_transfer_clock_pin_i(sync_transfer_clock_pin),
    .rx_pin_i(rx), .tx_pin_o(tx), .tx_pin_oe_o(oe), .rx_pin_owned_o(own));
  uart_partner uart_partner_i (.clock_i(clock_i), .tick_i(sm ? sync_transfer_clock_pin : tick), .tx_i(tx),
    .rx_o(rx));

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    r = rdata_o;
  endtask
  task automatic wait_tx();
    for (int i = 0; i < 600 && uart_partner_i.q.size() == 0; i++) @(posedge clock_i);
    f = (uart_partner_i.q.size() > 0) ? uart_partner_i.q.pop_front() : 'x;
  endtask
  function automatic logic [8:0] msk(input logic [8:0] d);
    return d & ((9'h1 << nb) - 9'h1);
  endfunction
  function automatic logic par(input logic [8:0] d);
    return ^msk(d) ^ po;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    #40000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(OFS_STATUS);
    chk("status", r, 8'h20);
    rd(OFS_CONTROL);
    chk("control", r, CONTROL_RESET);
    rd(OFS_FORMAT);
    chk("format", r, FORMAT_RESET);
    // Sizes 5..8 and nine, random parity and stop count
    for (int k = 0; k < 5; k++)
    begin
      code = (k == 4) ? SIZE_NINE : 3'(k);
      nb = (k == 4) ? 9 : k + 5;
      pe = $random(seed);
      po = $random(seed);
      ts = $random(seed);
      sm = (k == 2);
      dd[0] = $random(seed);
      dd[1] = $random(seed);
      uart_partner_i.nb = nb;
      uart_partner_i.pen = pe;
      wr(OFS_FORMAT, {ts, 1'b0, pe, po, sm, code});
      wr(OFS_CONTROL, 8'h78 | dd[0][8]);
      wr(OFS_DATA, dd[0][7:0]);
      wr(OFS_CONTROL, 8'h78 | dd[1][8]);
      wr(OFS_DATA, dd[1][7:0]);
      rd(OFS_STATUS);
      chk("empty flag", r[ST_TX_EMPTY], 0);
      chk("empty irq", irq_e, 0);
      chk("rx owned", own, 1);
      for (int j = 0; j < 2; j++)
      begin
        wait_tx();
        chk("tx data", msk(f[8:0]), msk(dd[j]));
        chk("tx parity", f[nb], pe ? par(dd[j]) : 1'b1);
        chk("tx stop", f[nb + pe], 1);
      end
      for (int i = 0; i < 100 && irq_c !== 1'b1; i++) @(posedge clock_i);
      wr(OFS_STATUS, 8'h00);
      rd(OFS_STATUS);
      chk("complete flag", r[ST_TX_DONE], 1);
      chk("empty idle", r[ST_TX_EMPTY], 1);
      chk("complete irq", irq_c, 1);
      chk("empty irq", irq_e, 1);
      @(posedge clock_i);
      gie <= 1'b0;
      #1;
      chk("gated irqs", {irq_c, irq_e}, 0);
      @(posedge clock_i);
      gie <= 1'b1;
      if (k[0])
        wr(OFS_STATUS, 8'h40);
      else
      begin
        @(posedge clock_i);
        ack <= 1'b1;
        @(posedge clock_i);
        ack <= 1'b0;
      end
      rd(OFS_STATUS);
      chk("complete clear", r[ST_TX_DONE], 0);
      // Two frames queued, second with wrong parity
      uart_partner_i.send(dd[0], par(dd[0]));
      uart_partner_i.send(dd[1], ~par(dd[1]));
      for (int j = 0; j < 2; j++)
      begin
        rd(OFS_STATUS);
        chk("rx complete", r[ST_RX_DONE], 1);
        chk("rx errors", {r[ST_FRAME_ERR], r[ST_OVERRUN], r[ST_PAR_ERR]}, j & pe);
        rd(OFS_CONTROL);
        chk("rx ninth", r[CT_RX_NINTH], (nb == 9) & dd[j][8]);
        rd(OFS_DATA);
        chk("rx data", r, msk(dd[j]) & 9'hff);
      end
      chk("rx drained", rx_ready, 0);
    end
    uart_partner_i.send(9'h0a5, 1'b0);
    #1;
    chk("rx pending", rx_ready, 1);
    wr(OFS_CONTROL, 8'h08);
    // Flush lands one edge after the control write
    repeat (2) @(posedge clock_i);
    #1;
    chk("rx flushed", rx_ready, 0);
    chk("rx released", own, 0);
    chk("empty irq off", irq_e, 0);
    wr(OFS_DATA, 8'h55);
    wr(OFS_CONTROL, 8'h00);
    chk("tx held", oe, 1);
    wait_tx();
    chk("tx last", f[7:0], 8'h55);
    for (int i = 0; i < 60 && oe !== 1'b0; i++) @(posedge clock_i);
    chk("tx released", oe, 0);
    finish_test();
  end
endmodule // testbench
